// ### hdl/sadc_readout.sv
`timescale 1ns/100ps
// Overview of operation
// - result leaves msb first; output changes on serial-clock falling edges.
// - serial clock alone steps the approximation, one bit per falling edge.
// - channel select high converts second input, low converts first input.
// - frame opens with one zero, then the result bits.
// - trailing zeros follow: two at 12 bits, four at 10, six at 8.
// - after power-down one whole frame is a wake-up frame with invalid data.
// - output floats while unselected, drives only after chip select falls.
// - power-down entry comes only from chip select timing, exit only at the tenth serial-clock falling edge.
// - chip select falling samples the input and starts a frame.
// - output floats during the sixteenth serial-clock cycle.
// - chip select rising between 2nd and 10th edge aborts and powers down.
module sadc_readout #(
  parameter int unsigned RES = sadc_pkg::RES_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic channel_select_pin_in,
  input wire logic [RES-1:0] analog_input_first_in,
  input wire logic [RES-1:0] analog_input_second_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  output logic powered_down_out
);
  // ----------------------------------------------------------------
  // state and edge detection
  // ----------------------------------------------------------------
  localparam logic [4:0] RES_CNT = 5'(RES);

  typedef struct packed {
    logic cs_n;      // chip select seen last cycle
    logic sclk;      // serial clock seen last cycle
    logic in_frame;
    logic dummy;     // frame started while powered down
    logic pwr_down;
    logic [4:0] cnt; // falling edges since chip select fell
    logic sdo;
    logic oe_n;
  } sadc_rd_st_t;

  sadc_rd_st_t st_r;
  sadc_rd_st_t st_nxt;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic [4:0] cnt_inc;

  sadc_conv_if #(.RES(RES)) cv ();

  sadc_sar_core #(.RES(RES)) u_core (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .cv(cv)
  );

  assign cs_fall = st_r.cs_n && !cs_n_in;
  assign cs_rise = !st_r.cs_n && cs_n_in;
  assign sclk_fall = st_r.sclk && !sclk_in;
  assign cnt_inc = (st_r.cnt == sadc_pkg::CNT_MAX) ? st_r.cnt : st_r.cnt + sadc_pkg::CNT_ONE;

  // ----------------------------------------------------------------
  // core control
  // ----------------------------------------------------------------
  // sample the selected input at the frame start
  assign cv.start = cs_fall;
  assign cv.sample = channel_select_pin_in ? analog_input_second_in
                                           : analog_input_first_in;
  assign cv.step = st_r.in_frame && !cs_rise && sclk_fall && (st_r.cnt < RES_CNT);

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  // next state from chip select and serial clock edges only
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_n = cs_n_in;
    st_nxt.sclk = sclk_in;
    if (cs_fall) begin
      st_nxt.in_frame = 1'b1;
      st_nxt.dummy = st_r.pwr_down;
      st_nxt.cnt = sadc_pkg::CNT_ZERO;
      st_nxt.sdo = 1'b0;
      st_nxt.oe_n = 1'b0;
    end else if (st_r.in_frame && cs_rise) begin
      st_nxt.in_frame = 1'b0;
      st_nxt.oe_n = 1'b1;
      st_nxt.sdo = 1'b0;
      if ((st_r.cnt >= sadc_pkg::PD_EDGE_LO) && (st_r.cnt < sadc_pkg::PD_EDGE_HI)) begin
        st_nxt.pwr_down = 1'b1;
      end
    end else if (st_r.in_frame && sclk_fall) begin
      st_nxt.cnt = cnt_inc;
      if (cnt_inc == sadc_pkg::PD_EDGE_HI) begin
        st_nxt.pwr_down = 1'b0;
      end
      if (cnt_inc >= sadc_pkg::HIZ_EDGE) begin
        st_nxt.oe_n = 1'b1;
        st_nxt.sdo = 1'b0;
      end else if (cnt_inc <= RES_CNT) begin
        st_nxt.sdo = cv.bit_val && !st_r.dummy;
      end else begin
        st_nxt.sdo = 1'b0;
      end
    end
  end

  // state register, floating and awake after reset
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      st_r <= '{cs_n: 1'b1, sclk: 1'b0, in_frame: 1'b0, dummy: 1'b0, pwr_down: 1'b0,
                cnt: 5'h00, sdo: 1'b0, oe_n: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign sdo_out = st_r.sdo;
  assign sdo_oe_n_out = st_r.oe_n;
  assign powered_down_out = st_r.pwr_down;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_frame_open;
    cs_fall ##1 (st_r.in_frame && !sdo_oe_n_out);
  endsequence

  sequence s_early_rise;
    st_r.in_frame && cs_rise && (st_r.cnt >= sadc_pkg::PD_EDGE_LO)
      && (st_r.cnt < sadc_pkg::PD_EDGE_HI);
  endsequence

  a_float_unselected: assert property (!st_r.in_frame |-> sdo_oe_n_out)
    else $error("serial output driven outside a frame");

  a_leading_zero: assert property (cs_fall |=> (!sdo_oe_n_out && !sdo_out))
    else $error("frame did not open with a driven zero");

  a_sample_chan: assert property (cs_fall |=>
    (cv.held == (($past(channel_select_pin_in)) ? $past(analog_input_second_in)
                                                : $past(analog_input_first_in))))
    else $error("wrong channel sampled");

  a_msb_first_bits: assert property ((st_r.in_frame && !cs_rise && sclk_fall && !st_r.dummy
    && (st_r.cnt < RES_CNT)) |=> (sdo_out == $past(cv.bit_val)))
    else $error("result bit not shifted on falling edge");

  a_trailing_zeros: assert property ((st_r.in_frame && !cs_rise && sclk_fall
    && (st_r.cnt >= RES_CNT) && (st_r.cnt < 5'h0E)) |=> (!sdo_out && !sdo_oe_n_out))
    else $error("trailing bit not a driven zero");

  a_hiz_sixteenth: assert property ((st_r.in_frame && !cs_rise && sclk_fall
    && (st_r.cnt == 5'h0E)) |=> sdo_oe_n_out)
    else $error("output not floated in the sixteenth cycle");

  a_abort_powerdown: assert property (s_early_rise |=>
    (powered_down_out && sdo_oe_n_out) ##1 powered_down_out)
    else $error("early chip select rise did not power down");

  a_wake_dummy: assert property ((st_r.pwr_down ##0 s_frame_open) |->
    (st_r.dummy && !sdo_out))
    else $error("wake-up frame not marked as dummy");

  a_wake_tenth: assert property ((st_r.pwr_down && st_r.in_frame && !cs_rise && sclk_fall
    && (st_r.cnt == 5'h09)) |=> !powered_down_out)
    else $error("ten-edge dummy frame did not wake the part");

  // ----------------------------------------------------------------
  // power and frame bookkeeping checks
  // ----------------------------------------------------------------
  // dummy frame keeps every driven slot at zero
  a_dummy_quiet: assert property ((st_r.in_frame && st_r.dummy) |-> !sdo_out)
    else $error("dummy frame drove a one");

  // very early rise floats the output but leaves power state alone
  a_rise_keeps_power: assert property ((st_r.in_frame && cs_rise
    && (st_r.cnt < sadc_pkg::PD_EDGE_LO)) |=> (sdo_oe_n_out && $stable(powered_down_out)))
    else $error("early rise before second edge changed power state");

  // rise after the tenth edge ends the frame awake
  a_late_rise_awake: assert property ((st_r.in_frame && cs_rise
    && (st_r.cnt >= sadc_pkg::PD_EDGE_HI)) |=> (sdo_oe_n_out && !powered_down_out))
    else $error("late chip select rise left the part powered down");

  // output stays floating for the rest of the frame
  a_float_held: assert property ((st_r.in_frame
    && (st_r.cnt >= sadc_pkg::HIZ_EDGE)) |-> sdo_oe_n_out)
    else $error("output driven after the sixteenth cycle began");

  // frame start restarts the edge count
  a_start_clears_count: assert property (cs_fall |=>
    (st_r.cnt == sadc_pkg::CNT_ZERO))
    else $error("edge count not cleared at frame start");

  // serial clock edges outside a frame are ignored
  a_count_frozen_idle: assert property ((!st_r.in_frame && !cs_fall) |=>
    $stable(st_r.cnt))
    else $error("edge count moved outside a frame");

  // driver turns on only right after chip select fell
  a_drive_after_fall: assert property ($fell(sdo_oe_n_out) |-> $past(cs_fall))
    else $error("output enabled without a chip select fall");

  // power-down entered only through a chip select rise
  a_pd_entry_cause: assert property ($rose(powered_down_out) |->
    $past(st_r.in_frame && cs_rise))
    else $error("power-down entered without chip select rise");

  // power-down left only at the tenth counted falling edge
  a_pd_exit_cause: assert property ($fell(powered_down_out) |->
    $past(st_r.in_frame && !cs_rise && sclk_fall && (cnt_inc == sadc_pkg::PD_EDGE_HI)))
    else $error("power-down left without a tenth falling edge");

  // held sample ignores input changes during the frame
  a_sample_held: assert property ((st_r.in_frame && !cs_fall) |=> $stable(cv.held))
    else $error("held sample changed within a frame");
endmodule

// ### hdl/sadc_sar_core.sv
`timescale 1ns/100ps
module sadc_sar_core #(
  parameter int unsigned RES = 12
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  sadc_conv_if.core cv
);
  typedef struct packed {
    logic [RES-1:0] sample;
    logic [RES-1:0] acc;
    logic [RES-1:0] weight;
  } sadc_core_st_t;

  sadc_core_st_t st_r;
  sadc_core_st_t st_nxt;
  logic [RES-1:0] trial;

  // ----------------------------------------------------------------
  // successive approximation, one bit per step, msb first
  // ----------------------------------------------------------------
  assign trial = st_r.acc | st_r.weight;
  assign cv.bit_val = (st_r.sample >= trial) && (st_r.weight != '0);
  assign cv.held = st_r.sample;

  // next state: start reloads, step decides and moves the weight down
  always_comb begin
    st_nxt = st_r;
    if (cv.start) begin
      st_nxt.sample = cv.sample;
      st_nxt.acc = '0;
      st_nxt.weight = {1'b1, {(RES-1){1'b0}}};
    end else if (cv.step) begin
      if (cv.bit_val) begin
        st_nxt.acc = trial;
      end
      st_nxt.weight = st_r.weight >> 1;
    end
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_weight_moves_down: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (cv.step && !cv.start) |=> (st_r.weight == ($past(st_r.weight) >> 1)))
    else $error("approximation weight did not step down");
endmodule

// ### pkg/sadc_conv_if.sv
`timescale 1ns/100ps
interface sadc_conv_if #(parameter int unsigned RES = 12);
  logic start;           // load a new sample, clear the approximation
  logic [RES-1:0] sample;
  logic step;            // decide one bit
  logic bit_val;         // bit decided by the next step
  logic [RES-1:0] held;  // sample held by the core
  modport ctrl (output start, output sample, output step, input bit_val, input held);
  modport core (input start, input sample, input step, output bit_val, output held);
endinterface

// ### pkg/sadc_pkg.sv
package sadc_pkg;
  // ----------------------------------------------------------------
  // frame layout, counted in serial-clock falling edges
  // ----------------------------------------------------------------
  localparam int unsigned RES_DEFAULT = 12;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] PD_EDGE_LO = 5'h02;  // abort window opens after 2nd edge
  localparam logic [4:0] PD_EDGE_HI = 5'h0A;  // frame is safe from 10th edge on
  localparam logic [4:0] HIZ_EDGE = 5'h0F;    // 15th edge starts 16th cycle
  localparam logic [4:0] CNT_MAX = 5'h10;
  // ----------------------------------------------------------------
  // timing, fastest serial clock against the system clock
  // ----------------------------------------------------------------
  localparam int unsigned REF_PERIOD_PS = 4000;
  localparam int unsigned SCLK_MIN_PERIOD_PS = 125000;  // 8 MHz full rate
  localparam int unsigned SCLK_MIN_CYCLES = SCLK_MIN_PERIOD_PS / REF_PERIOD_PS;
endpackage

// ### verif/sadc_host_model.sv
`timescale 1ns/100ps
module sadc_host_model (
  input wire logic clk_in,
  output logic cs_n_out,
  output logic sclk_out,
  input wire logic [2:0] sdo_in,
  input wire logic [2:0] oe_n_in
);
  // half period just long enough for the full-rate serial clock
  localparam int unsigned HALF = sadc_pkg::SCLK_MIN_CYCLES / 2 + 1;
  logic [2:0] cap_d [0:16];
  logic [2:0] cap_oe [0:16];
  // serial clock stands high between frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
  end
  // one frame of n falls; slot k is taken just before fall k+1
  task automatic frame(input int n);
    cs_n_out = 1'b0;
    repeat (2) @(negedge clk_in);
    for (int k = 0; k <= n; k++) begin
      cap_d[k] = sdo_in;
      cap_oe[k] = oe_n_in;
      if (k < n) begin
        sclk_out = 1'b0;
        repeat (HALF) @(negedge clk_in);
        sclk_out = 1'b1;
        repeat (HALF) @(negedge clk_in);
      end
    end
    cs_n_out = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic channel_select_pin = 1'b0;
  logic [11:0] analog_input_first = 12'h000;
  logic [11:0] analog_input_second = 12'h000;
  logic cs_n;
  logic sclk;
  logic [2:0] sdo;
  logic [2:0] oe_n;
  logic [2:0] pd;
  int n_fail = 0;
  int num_checks = 0;
  // 250 MHz reference clock
  initial begin
    forever #2 clk = ~clk;
  end
  sadc_host_model host_u (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk), .sdo_in(sdo),
    .oe_n_in(oe_n));
  // one converter each at 12, 10 and 8 bits on the same host lines
  for (genvar i = 0; i < 3; i++) begin : g_res
    localparam int unsigned R = 12 - 2 * i;
    logic [R-1:0] first_w;
    logic [R-1:0] second_w;
    // low bits of the shared codes feed each resolution
    assign first_w = analog_input_first[R-1:0];
    assign second_w = analog_input_second[R-1:0];
    sadc_readout #(.RES(R)) dut_u (.ref_clk_in(clk), .resetn_in(rst_n), .cs_n_in(cs_n),
      .sclk_in(sclk), .channel_select_pin_in(channel_select_pin), .analog_input_first_in(first_w),
      .analog_input_second_in(second_w), .sdo_out(sdo[i]), .sdo_oe_n_out(oe_n[i]),
      .powered_down_out(pd[i]));
  end
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask
  // whole frame: lead zero, msb first, trailing zeros, float from slot 15
  task automatic chk_frame(input logic [11:0] v, input logic dummy);
    logic [2:0] e;
    for (int k = 0; k <= 16; k++) begin
      e = 3'h0;
      for (int i = 0; i < 3; i++) begin
        if (k >= 1 && k <= 12 - 2 * i && !dummy) begin
          e[i] = v[12 - 2 * i - k];
        end
      end
      check(host_u.cap_oe[k], (k >= 15) ? 3'h7 : 3'h0);
      if (k < 15) begin
        check(host_u.cap_d[k], e);
      end
    end
  endtask
  // input change after the sampling edge must not reach the result
  task automatic t_normal();
    analog_input_first = 12'hA5C;
    analog_input_second = 12'h3C6;
    fork
      host_u.frame(16);
      begin
        repeat (3) @(negedge clk);
        analog_input_first = 12'h5A3;
      end
    join
    chk_frame(12'hA5C, 1'b0);
    channel_select_pin = 1'b1;
    host_u.frame(16);
    chk_frame(12'h3C6, 1'b0);
    channel_select_pin = 1'b0;
    $display("test normal done");
  endtask
  // abort window edges, power-down, dummy wake frame, valid frame
  task automatic t_power();
    host_u.frame(1);
    check(pd, 3'h0);
    host_u.frame(10);
    check(pd, 3'h0);
    host_u.frame(2);
    check(pd, 3'h7);
    check(oe_n, 3'h7);
    host_u.frame(16);
    chk_frame(12'h000, 1'b1);
    check(pd, 3'h0);
    host_u.frame(16);
    chk_frame(12'h5A3, 1'b0);
    $display("test power done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog about four times the roughly 2500 cycles the tests need
  initial begin
    #40000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(oe_n, 3'h7);
    t_normal();
    t_power();
    tally_and_finish();
  end
endmodule
